// file: design/bsm_defines.svh
/*
 * Constants of the backplane sync and module-link block: timing counts,
 * slot layout and reset values.
 * Assumes a 40 MHz system clock; every cycle count below is derived from it.
 */
`ifndef BSM_DEFINES_SVH
`define BSM_DEFINES_SVH

`define BSM_SYS_KHZ        40000
`define BSM_SYS_PERIOD_PS  25000
`define BSM_SER_RATE_KBPS  6250
`define BSM_BAUD_DEN_BITS  5
`define BSM_BAUD_STEP      ((`BSM_SER_RATE_KBPS * 32) / `BSM_SYS_KHZ)
`define BSM_LAG_NS         10
`define BSM_LAG_CYC        ((`BSM_LAG_NS * 1000 + `BSM_SYS_PERIOD_PS - 1) / `BSM_SYS_PERIOD_PS)
`define BSM_LOSS_NS        600
`define BSM_LOSS_CYC       ((`BSM_LOSS_NS * 1000) / `BSM_SYS_PERIOD_PS)
`define BSM_LOCK_EDGES     4
`define BSM_INT_HALF_NS    100
`define BSM_INT_HALF_CYC   ((`BSM_INT_HALF_NS * 1000) / `BSM_SYS_PERIOD_PS)
`define BSM_NUM_SLOTS      12
`define BSM_FAST_SLOT_MASK 12'h0F0
`define BSM_SER_FRAME_BITS 10
`define BSM_RST_CORE_RESET 1'b1
`define BSM_RST_NEED_CFG   1'b1

`endif

// file: design/bsm_pkg.sv
/*
 * Types of the backplane sync and module-link block.
 * Assumes bsm_defines.svh is compiled alongside for the constants.
 */
package bsm_pkg;

	typedef enum logic [1:0] {
		BSM_ABSENT,
		BSM_EXT,
		BSM_HUNG
	} bsm_det_t;

endpackage

// file: design/bsm_pin_sync.sv
/*
 * Two-stage synchroniser for a group of pins, with edge detection.
 * Assumes the pins are asynchronous to clk_sys_i.
 */
`timescale 1ns/1ps
module bsm_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys_i,
	input  wire logic         arst_n_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o,
	output logic      [W-1:0] rise_o
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;
	logic [W-1:0] prev_reg;

	// Only sync_reg reads meta_reg; edges are taken from the settled stages.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= pin_i;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign level_o = sync_reg;
	assign rise_o  = sync_reg & ~prev_reg;
endmodule // bsm_pin_sync

// file: design/bsm_sync_top.sv
/*
 * Backplane sync chain and module-slot signal logic.
 * Assumes sync and slot pins are asynchronous; command inputs are
 * one-cycle pulses from logic on clk_sys_i.
 */
// Function
// R1: Select external sync clock when detected, else internal.
// R2: External mode routes sync reset/load to cores.
// R3: Chain outputs follow inputs, else internal signals.
// R4: Output feeds next controller; master lacks input.
// R5: Host holds cores, configures, then releases.
// R6: Chain lag is fixed, about 10 ns; code lags two to three clk_sys_i cycles, 50-75 ns.
// R7: Host stages parameters, then commits them.
// R8: Clock loss hangs; restore reboots, needs configuration.
// R9: Module grounds its presence line when installed.
// R10: Low thermal alarm line means module overheating.
// R11: Low power-down line keeps module powered down.
// R12: Modules get master clock, reset, load lines.
// R13: Serial link runs 6.25 Mbps each direction; code has only the transmit side.
// R14: ADC returns bit clock, frame clock, data.
// R15: Fast converter: four inputs, 16 bits, 100 MHz.
// R16: Multichannel converter: eighteen inputs, 18 bits, 12.5 MHz.
// R17: Fast converters only accepted in slots 5-8.
// R18: Reset and load are registered before fan-out.
`timescale 1ns/1ps
`include "bsm_defines.svh"
module bsm_sync_top #(
	parameter int NSLOT = `BSM_NUM_SLOTS
) (
	input  wire logic             clk_sys_i,
	input  wire logic             arst_n_i,
	input  wire logic             sync_clock_in_i,
	input  wire logic             sync_reset_in_i,
	input  wire logic             sync_load_in_i,
	input  wire logic             timing_hold_cmd_i,
	input  wire logic             timing_release_cmd_i,
	input  wire logic             param_commit_cmd_i,
	input  wire logic             config_done_i,
	input  wire logic [NSLOT-1:0] present_n_i,
	input  wire logic [NSLOT-1:0] thermal_alarm_n_i,
	input  wire logic [NSLOT-1:0] fast_adc_i,
	input  wire logic [NSLOT-1:0] power_down_req_i,
	input  wire logic [7:0]       ser_tx_data_i,
	input  wire logic             ser_tx_valid_i,
	output bsm_pkg::bsm_det_t     det_state_o,
	output logic                  clk_sel_ext_o,
	output logic                  ext_clock_ok_o,
	output logic                  hang_o,
	output logic                  reboot_req_o,
	output logic                  need_config_o,
	output logic                  core_reset_o,
	output logic                  core_load_o,
	output logic                  module_reset_o,
	output logic                  module_load_o,
	output logic                  sync_clock_out_o,
	output logic                  sync_reset_out_o,
	output logic                  sync_load_out_o,
	output logic [NSLOT-1:0]      slot_present_o,
	output logic [NSLOT-1:0]      slot_alarm_o,
	output logic [NSLOT-1:0]      module_standby_n_o,
	output logic [NSLOT-1:0]      adc_slot_fault_o,
	output logic                  ser_tx_ready_o,
	output logic                  serial_from_backplane_o
);
	import bsm_pkg::*;

	localparam logic [4:0] LOSS_CYC  = 5'(`BSM_LOSS_CYC);
	localparam logic [2:0] LOCK_LAST = 3'(`BSM_LOCK_EDGES - 1);
	localparam logic [2:0] HALF_LAST = 3'(`BSM_INT_HALF_CYC - 1);
	localparam logic [5:0] BAUD_STEP = 6'(`BSM_BAUD_STEP);
	localparam logic [3:0] FRAME_LAST = 4'(`BSM_SER_FRAME_BITS - 1);

	logic [2:0]       chain_lvl;
	logic [2:0]       chain_rise;
	logic [NSLOT-1:0] pres_s;
	logic [NSLOT-1:0] alarm_s;
	logic [NSLOT-1:0] fast_s;
	logic             clk_s;
	logic             clk_rise;
	logic             rst_s;
	logic             load_s;
	bsm_det_t         state_reg;
	logic [2:0]       edges_reg;
	logic [4:0]       gap_reg;
	logic             hold_reg;
	logic [2:0]       div_reg;
	logic             int_clk_reg;
	logic             ext_mode;
	logic             int_reset;
	logic [4:0]       baud_reg;
	logic [5:0]       baud_next;
	logic             bit_en;
	logic [9:0]       shift_reg;
	logic [3:0]       bitcnt_reg;

	bsm_pin_sync #(.W(3)) u_chain_sync (
		.clk_sys_i (clk_sys_i),
		.arst_n_i  (arst_n_i),
		.pin_i     ({sync_load_in_i, sync_reset_in_i, sync_clock_in_i}),
		.level_o   (chain_lvl),
		.rise_o    (chain_rise)
	);

	bsm_pin_sync #(.W(3 * NSLOT)) u_slot_sync (
		.clk_sys_i (clk_sys_i),
		.arst_n_i  (arst_n_i),
		.pin_i     ({fast_adc_i, thermal_alarm_n_i, present_n_i}),
		.level_o   ({fast_s, alarm_s, pres_s}),
		.rise_o    ()
	);

	assign clk_s    = chain_lvl[0];
	assign clk_rise = chain_rise[0];
	assign rst_s    = chain_lvl[1];
	assign load_s   = chain_lvl[2];
	assign ext_mode = (state_reg == BSM_EXT);
	assign int_reset = hold_reg | need_config_o;

	// Cycles since the last sync clock edge, saturating at the loss limit.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gap_reg <= 5'h00;
		end else if (clk_rise) begin
			gap_reg <= 5'h00;
		end else if (gap_reg != LOSS_CYC) begin
			gap_reg <= gap_reg + 5'h01;
		end
	end

	// Clock detector. Several clean edges are needed before switching, so
	// a glitch on an open chain input cannot steal the master clock.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= BSM_ABSENT;
			edges_reg <= 3'h0;
		end else begin
			case (state_reg)
			BSM_ABSENT: begin
				if (clk_rise) begin
					if (edges_reg == LOCK_LAST) begin
						state_reg <= BSM_EXT; // R1 R4
						edges_reg <= 3'h0;
					end else begin
						edges_reg <= edges_reg + 3'h1;
					end
				end else if (gap_reg == LOSS_CYC) begin
					edges_reg <= 3'h0;
				end
			end
			BSM_EXT: begin
				if (gap_reg == LOSS_CYC) begin
					state_reg <= BSM_HUNG; // R8
				end
			end
			BSM_HUNG: begin
				if (clk_rise) begin
					state_reg <= BSM_ABSENT; // R8
				end
			end
			default: state_reg <= BSM_ABSENT;
			endcase
		end
	end

	// PLL source select and status flags.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			det_state_o    <= BSM_ABSENT;
			clk_sel_ext_o  <= 1'b0;
			ext_clock_ok_o <= 1'b0;
			hang_o         <= 1'b0;
			reboot_req_o   <= 1'b0;
		end else begin
			det_state_o    <= state_reg;
			clk_sel_ext_o  <= (state_reg != BSM_ABSENT); // R1
			ext_clock_ok_o <= ext_mode;
			hang_o         <= (state_reg == BSM_HUNG); // R8
			reboot_req_o   <= (state_reg == BSM_HUNG) && clk_rise; // R8
		end
	end

	// After a reboot the timing cores stay held until software configures; once the external clock locks again they follow sync reset instead.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			need_config_o <= `BSM_RST_NEED_CFG;
		end else if ((state_reg == BSM_HUNG) && clk_rise) begin
			need_config_o <= 1'b1; // R8
		end else if (config_done_i) begin
			need_config_o <= 1'b0;
		end
	end

	// Hold wins over release when both arrive together.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hold_reg <= `BSM_RST_CORE_RESET;
		end else if (timing_hold_cmd_i) begin
			hold_reg <= 1'b1; // R5
		end else if (timing_release_cmd_i) begin
			hold_reg <= 1'b0; // R5
		end
	end

	// Internal chain clock from a divider of the system clock.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_reg     <= 3'h0;
			int_clk_reg <= 1'b0;
		end else if (div_reg == HALF_LAST) begin
			div_reg     <= 3'h0;
			int_clk_reg <= ~int_clk_reg;
		end else begin
			div_reg <= div_reg + 3'h1;
		end
	end

	// One register stage from the settled inputs to every core and every
	// slot, so all see the strobe on the same edge with a fixed lag.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			core_reset_o     <= `BSM_RST_CORE_RESET;
			core_load_o      <= 1'b0;
			module_reset_o   <= `BSM_RST_CORE_RESET;
			module_load_o    <= 1'b0;
			sync_clock_out_o <= 1'b0;
			sync_reset_out_o <= `BSM_RST_CORE_RESET;
			sync_load_out_o  <= 1'b0;
		end else if (ext_mode) begin
			core_reset_o     <= rst_s; // R2 R18
			core_load_o      <= load_s; // R2 R18
			module_reset_o   <= rst_s; // R12
			module_load_o    <= load_s; // R12
			sync_clock_out_o <= clk_s; // R3 R6
			sync_reset_out_o <= rst_s; // R3
			sync_load_out_o  <= load_s; // R3
		end else begin
			core_reset_o     <= int_reset; // R18
			core_load_o      <= param_commit_cmd_i; // R7 R18
			module_reset_o   <= int_reset; // R12
			module_load_o    <= param_commit_cmd_i; // R12
			sync_clock_out_o <= int_clk_reg; // R3
			sync_reset_out_o <= int_reset; // R3
			sync_load_out_o  <= param_commit_cmd_i; // R3
		end
	end

	// Slot status. A fast converter outside the central slots is refused.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			slot_present_o     <= '0;
			slot_alarm_o       <= '0;
			module_standby_n_o <= '0;
			adc_slot_fault_o   <= '0;
		end else begin
			slot_present_o     <= ~pres_s; // R9
			slot_alarm_o       <= ~alarm_s & ~pres_s; // R10
			module_standby_n_o <= ~power_down_req_i; // R11
			adc_slot_fault_o   <= fast_s & ~pres_s
				& ~NSLOT'(`BSM_FAST_SLOT_MASK); // R17
		end
	end

	// 6.25 Mbps from 40 MHz is exactly 5 bit times per 32 cycles, so a
	// phase accumulator keeps the average rate exact with a small jitter.
	assign baud_next = {1'b0, baud_reg} + BAUD_STEP;
	assign bit_en    = baud_next[5];

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			baud_reg <= 5'h00;
		end else begin
			baud_reg <= baud_next[4:0]; // R13
		end
	end

	// Frame: start bit low, eight data bits first LSB, stop bit high.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shift_reg               <= 10'h3FF;
			bitcnt_reg              <= 4'h0;
			ser_tx_ready_o          <= 1'b1;
			serial_from_backplane_o <= 1'b1;
		end else if (ser_tx_ready_o) begin
			if (ser_tx_valid_i) begin
				shift_reg      <= {1'b1, ser_tx_data_i, 1'b0};
				bitcnt_reg     <= 4'h0;
				ser_tx_ready_o <= 1'b0;
			end
		end else if (bit_en) begin
			serial_from_backplane_o <= shift_reg[0]; // R13
			shift_reg               <= {1'b1, shift_reg[9:1]};
			if (bitcnt_reg == FRAME_LAST) begin
				ser_tx_ready_o <= 1'b1;
			end else begin
				bitcnt_reg <= bitcnt_reg + 4'h1;
			end
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	a_sel_after_lock: assert property ( // R1
		$rose(state_reg == BSM_EXT) |=> clk_sel_ext_o && ext_clock_ok_o)
		else $error("PLL source not switched after lock");
	a_ext_reset_route: assert property ( // R2
		ext_mode |=> core_reset_o == $past(rst_s))
		else $error("Core reset does not follow sync reset");
	a_int_reset_route: assert property ( // R5
		!ext_mode |=> core_reset_o == $past(int_reset))
		else $error("Core reset does not follow internal hold");
	a_chain_clock: assert property ( // R3
		ext_mode |=> sync_clock_out_o == $past(clk_s))
		else $error("Chain clock not forwarded");
	a_loss_hangs: assert property ( // R8
		ext_mode && gap_reg == LOSS_CYC |=> state_reg == BSM_HUNG ##1 hang_o)
		else $error("Clock loss not flagged");
	a_reboot_config: assert property ( // R8
		reboot_req_o |-> need_config_o ##1 !reboot_req_o)
		else $error("Reboot without configuration demand");
	a_same_edge: assert property ( // R18
		core_reset_o == module_reset_o && core_load_o == module_load_o)
		else $error("Core and module strobes differ");
	a_standby_map: assert property ( // R11
		1'b1 |=> module_standby_n_o == ~$past(power_down_req_i))
		else $error("Power-down request not driven low");
	a_central_only: assert property ( // R17
		(adc_slot_fault_o & NSLOT'(`BSM_FAST_SLOT_MASK)) == '0)
		else $error("Central slot refused a fast converter");
	a_frame_stop: assert property ( // R13
		$rose(ser_tx_ready_o) |-> serial_from_backplane_o)
		else $error("Serial frame did not end on stop bit");

	c_ext_lock: cover property ($rose(ext_clock_ok_o));
	c_reboot: cover property (reboot_req_o);
	c_tx_frame: cover property ($rose(ser_tx_ready_o));
	c_release: cover property ($fell(core_reset_o));
endmodule // bsm_sync_top

// file: verification/bsm_upstream_model.sv
/*
 * Upstream chain neighbour and module-side serial receiver.
 * Assumes the bench enables the chain clock only while a link is wanted.
 */
`timescale 1ns/1ps
module bsm_upstream_model (
	input  wire logic clk_en_i,
	input  wire logic line_i,
	output logic      sync_clock_o,
	output logic [7:0] rx_byte_o,
	output int        rx_count_o
);
	// The chain clock stands still low while clk_en_i is low, as a pulled cable does.
	initial begin
		sync_clock_o = 1'b0;
		#7;
		forever begin
			#100;
			if (clk_en_i) begin
				sync_clock_o = ~sync_clock_o;
			end else begin
				sync_clock_o = 1'b0;
			end
		end
	end

	// Samples mid-bit at 160 ns per bit; a bad stop bit is not counted.
	initial begin
		rx_count_o = 0;
		rx_byte_o = 8'h00;
		forever begin
			@(negedge line_i);
			#240;
			for (int i = 0; i < 8; i++) begin
				rx_byte_o[i] = line_i;
				#160;
			end
			if (line_i === 1'b1) begin
				rx_count_o = rx_count_o + 1;
			end
		end
	end
endmodule // bsm_upstream_model

// file: verification/testbench.sv
/*
 * Self-checking bench of the backplane sync block.
 * Assumes the design files and the upstream model are compiled first.
 */
`timescale 1ns/1ps
`include "bsm_defines.svh"
module testbench;
	import bsm_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic        rst_in, ld_in, hold, rel, commit, cfg, tx_v, clk_en;
	logic [11:0] pres_n, alarm_n, fast, pd;
	logic [11:0] present, alarm, standby_n, fault;
	logic [7:0]  tx_d, rx_byte, b;
	bsm_det_t    det;
	logic        sel, ext_ok, hang, reboot, need_cfg, c_rst, c_ld, m_rst;
	logic        m_ld, sclk, s_rst, s_ld, ready, line, sync_clk;
	logic        pv;
	int          rx_count, err_total, checked, n;
	int          seed = 32'hCB94;

	always #12.5 clk_sys_i = ~clk_sys_i;

	bsm_upstream_model u_far (.clk_en_i(clk_en), .line_i(line),
		.sync_clock_o(sync_clk), .rx_byte_o(rx_byte), .rx_count_o(rx_count));

	bsm_sync_top u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.sync_clock_in_i(sync_clk), .sync_reset_in_i(rst_in),
		.sync_load_in_i(ld_in), .timing_hold_cmd_i(hold),
		.timing_release_cmd_i(rel), .param_commit_cmd_i(commit),
		.config_done_i(cfg), .present_n_i(pres_n),
		.thermal_alarm_n_i(alarm_n), .fast_adc_i(fast),
		.power_down_req_i(pd), .ser_tx_data_i(tx_d), .ser_tx_valid_i(tx_v),
		.det_state_o(det), .clk_sel_ext_o(sel), .ext_clock_ok_o(ext_ok),
		.hang_o(hang), .reboot_req_o(reboot), .need_config_o(need_cfg),
		.core_reset_o(c_rst), .core_load_o(c_ld), .module_reset_o(m_rst),
		.module_load_o(m_ld), .sync_clock_out_o(sclk),
		.sync_reset_out_o(s_rst), .sync_load_out_o(s_ld),
		.slot_present_o(present), .slot_alarm_o(alarm),
		.module_standby_n_o(standby_n), .adc_slot_fault_o(fault),
		.ser_tx_ready_o(ready), .serial_from_backplane_o(line));

	function automatic logic [11:0] exp_fault(input logic [11:0] p, f);
		return f & ~p & ~12'h0F0;
	endfunction

	task chk(input logic [11:0] s, input logic [11:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask

	task cyc(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#(25 * 60000);
		err_total++;
		close_out();
	end

	initial begin
		{rst_in, ld_in, hold, rel, commit, cfg, tx_v, clk_en} = 8'h00;
		{pres_n, alarm_n} = {12'hFFF, 12'hFFF};
		{fast, pd} = {12'h000, 12'h000};
		tx_d = 8'h00;
		repeat (10) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		cyc(1);
		chk(c_rst & m_rst & s_rst, 1'b1);
		chk(need_cfg, 1'b1);
		chk({sel, line, ready}, 3'b011);
		// Internal chain clock: one toggle per divider half period.
		n = 0;
		pv = sclk;
		for (int i = 0; i < 16; i++) begin
			cyc(1);
			if (sclk !== pv) begin
				n++;
			end
			pv = sclk;
		end
		chk(12'(n), 12'(16 / `BSM_INT_HALF_CYC));
		// Internal load strobe reaches cores, modules and chain together.
		@(posedge clk_sys_i) commit <= 1'b1;
		@(posedge clk_sys_i) commit <= 1'b0;
		#1;
		chk({c_ld, m_ld, s_ld}, 3'b111);
		cyc(1);
		chk({c_ld, m_ld, s_ld}, 3'b000);
		// Configure, release, then hold and release in one cycle.
		@(posedge clk_sys_i) cfg <= 1'b1;
		@(posedge clk_sys_i) {cfg, rel} <= 2'b01;
		@(posedge clk_sys_i) rel <= 1'b0;
		cyc(2);
		chk({c_rst, m_rst, s_rst, need_cfg}, 4'h0);
		@(posedge clk_sys_i) {hold, rel} <= 2'b11;
		@(posedge clk_sys_i) {hold, rel} <= 2'b00;
		cyc(2);
		chk({c_rst, m_rst}, 2'b11);
		@(posedge clk_sys_i) rel <= 1'b1;
		@(posedge clk_sys_i) rel <= 1'b0;
		cyc(2);
		chk(c_rst, 1'b0);
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_sys_i);
			pres_n <= (i == 0) ? 12'h000 : 12'($random(seed));
			alarm_n <= (i == 1) ? 12'h000 : 12'($random(seed));
			fast <= (i == 0) ? 12'hFFF : 12'($random(seed));
			pd <= 12'($random(seed));
			cyc(5);
			chk(present, ~pres_n);
			chk(alarm, ~alarm_n & ~pres_n);
			chk(standby_n, ~pd);
			chk(fault, exp_fault(pres_n, fast));
		end
		for (int i = 0; i < 5; i++) begin
			b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
			@(posedge clk_sys_i) {tx_v, tx_d} <= {1'b1, b};
			n = 0;
			do begin
				@(posedge clk_sys_i);
				n++;
			end while (ready !== 1'b1 && n < 200);
			tx_v <= 1'b0;
			n = 0;
			while (rx_count != i + 1 && n < 150) begin
				cyc(1);
				n++;
			end
			chk(rx_byte, b);
		end
		// External clock: lock, then reset and load routed with lag.
		@(posedge clk_sys_i) clk_en <= 1'b1;
		n = 0;
		while (ext_ok !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		chk({sel, ext_ok, det}, {2'b11, BSM_EXT});
		@(posedge clk_sys_i) rst_in <= 1'b1;
		cyc(2);
		chk(c_rst, 1'b0);
		cyc(1);
		chk({c_rst, m_rst, s_rst}, 3'b111);
		@(posedge clk_sys_i) {rst_in, ld_in} <= 2'b01;
		@(posedge clk_sys_i) ld_in <= 1'b0;
		cyc(2);
		chk({c_rst, c_ld, s_ld}, 3'b011);
		// Pull the cable, then plug it back in.
		@(posedge clk_sys_i) clk_en <= 1'b0;
		n = 0;
		while (hang !== 1'b1 && n < 60) begin
			cyc(1);
			n++;
		end
		chk({hang, sel, det}, {2'b11, BSM_HUNG});
		@(posedge clk_sys_i) clk_en <= 1'b1;
		n = 0;
		while (reboot !== 1'b1 && n < 60) begin
			cyc(1);
			n++;
		end
		chk({reboot, need_cfg}, 2'b11);
		cyc(1);
		chk({reboot, det}, {1'b0, BSM_ABSENT});
		close_out();
	end
endmodule // testbench
